// *** verilog/serial_usart_defines.vh ***
/*
  Constants of the serial control sequencer: register offsets, mode and command
  fields, reset values and bus answers. Assumes inclusion by bare name.
*/
`ifndef SERIAL_USART_DEFINES_VH
`define SERIAL_USART_DEFINES_VH
// Notes on behaviour
// - Serialise host bytes; assemble received bits into bytes.
// - First control write after reset is mode.
// - Mode selects sync or async field decoding.
// - Sync mode: length, parity, external sync, sync count.
// - Async mode: factor 1/16/64, length, parity, stop bits.
// - Sync mode: following control writes are sync characters.
// - Skip second sync character when single; skip both when async.
// - Store sync pattern and use it for framing.
// - After setup every control write is a command.
// - No transfer before a command is written.
// - Commands anytime after mode and sync characters; setting persists.
// - Internal reset bit returns to mode wait.
// - Either reset makes next control write mode.
// - Sync phase writes are sync even if reset-like.
// - Even port data, odd port control and status; here data is at 0x00, control and status at 0x04.
// - Odd port read returns status with ready bits; here the status read is at 0x04.
// - Separate transmit-ready, empty, receive-ready outputs.
// - Board reset idles device awaiting control words.
`define REG_DATA_OFS 8'h00
`define REG_CTRL_OFS 8'h04
`define REG_DIV_OFS  8'h08
`define DIV_RESET    16'h0001
`define MODE_BAUD    1:0
`define MODE_LEN     3:2
`define MODE_PEN     4
`define MODE_EP      5
`define MODE_STOP    7:6
`define MODE_ESD     6
`define MODE_SCS     7
`define BAUD_SYNC    2'h0
`define BAUD_X1      2'h1
`define BAUD_X16     2'h2
`define BAUD_X64     2'h3
`define FACT_X1      7'h01
`define FACT_X16     7'h10
`define FACT_X64     7'h40
`define STOP_15      2'h2
`define STOP_2       2'h3
`define LEN_BASE     4'h5
`define CMD_TXEN     0
`define CMD_RXE      2
`define CMD_SBRK     3
`define CMD_ER       4
`define CMD_IR       6
`define CMD_EH       7
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// *** verilog/serial_tx.v ***
/*
  Transmit shifter: data LSB first and parity, framed by start and stop bits in async mode only.
  Assumes tick is a one-cycle pulse at the sampling-clock rate.
*/
`timescale 1ns/1ns
`include "serial_usart_defines.vh"
module serial_tx (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       tick,
    input  wire       load,
    input  wire [7:0] data,
    input  wire [6:0] factor,
    input  wire [7:0] stop_ticks,
    input  wire [3:0] char_len,
    input  wire       parity_en,
    input  wire       parity_even,
    input  wire       sync_mode,
    input  wire       brk,
    output reg        txd,
    output wire       busy
);
localparam T_IDLE = 3'h0, T_START = 3'h1, T_DATA = 3'h2, T_PAR = 3'h3, T_STOP = 3'h4;
reg  [2:0] state_reg;
reg  [7:0] cnt_reg;
reg  [7:0] sh_reg;
reg  [3:0] nb_reg;
reg        par_reg;
wire [7:0] mask        = 8'hFF >> (4'h8 - char_len);
wire [7:0] reload      = {1'b0, factor} - 8'h01;
wire [7:0] stop_reload = stop_ticks - 8'h01;
assign busy = (state_reg != T_IDLE);
always @(posedge aclk) begin
    if (!aresetn) begin
        state_reg <= T_IDLE;
        cnt_reg   <= 8'h00;
        sh_reg    <= 8'h00;
        nb_reg    <= 4'h0;
        par_reg   <= 1'b0;
        txd       <= 1'b1;
    end else begin
        txd <= brk ? 1'b0 : (state_reg == T_START) ? 1'b0 :
               (state_reg == T_DATA) ? sh_reg[0] : (state_reg == T_PAR) ? par_reg : 1'b1;
        if (state_reg == T_IDLE) begin
            if (load) begin
                sh_reg    <= data;
                nb_reg    <= 4'h0;
                cnt_reg   <= reload;
                par_reg   <= (^(data & mask)) ^ ~parity_even;
                state_reg <= sync_mode ? T_DATA : T_START;
            end
        end else if (tick) begin
            if (cnt_reg != 8'h00) begin
                cnt_reg <= cnt_reg - 8'h01;
            end else begin
                cnt_reg <= reload;
                case (state_reg)
                    T_START: state_reg <= T_DATA;
                    T_DATA: begin
                        sh_reg <= sh_reg >> 1;
                        nb_reg <= nb_reg + 4'h1;
                        if (nb_reg == char_len - 4'h1) begin
                            state_reg <= parity_en ? T_PAR : (sync_mode ? T_IDLE : T_STOP);
                            if (!parity_en && !sync_mode) cnt_reg <= stop_reload;
                        end
                    end
                    T_PAR: begin
                        state_reg <= sync_mode ? T_IDLE : T_STOP;
                        if (!sync_mode) cnt_reg <= stop_reload;
                    end
                    default: state_reg <= T_IDLE;
                endcase
            end
        end
    end
end
endmodule // serial_tx

// *** verilog/serial_rx.v ***
/*
  Receive shifter: async start/stop framing or sync hunt on stored pattern.
  Assumes rxd is synchronised and tick comes no more than every other cycle.
*/
`timescale 1ns/1ns
`include "serial_usart_defines.vh"
module serial_rx (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       rxd,
    input  wire       tick,
    input  wire       enable,
    input  wire       hunt,
    input  wire       sync_mode,
    input  wire       ext_sync,
    input  wire       single_sync,
    input  wire [6:0] factor,
    input  wire [3:0] char_len,
    input  wire       parity_en,
    input  wire       parity_even,
    input  wire [7:0] sync1,
    input  wire [7:0] sync2,
    output reg        char_valid,
    output reg  [7:0] char_data,
    output reg        parity_err,
    output reg        frame_err,
    output reg        sync_found
);
localparam R_IDLE = 3'h0, R_START = 3'h1, R_DATA = 3'h2, R_PAR = 3'h3;
localparam R_STOP = 3'h4, R_HUNT = 3'h5, R_DONE = 3'h6;
reg  [2:0] state_reg;
reg  [7:0] cnt_reg;
reg  [7:0] sh_reg;
reg  [3:0] nb_reg;
reg        second_reg;
reg        perr_reg;
reg        ferr_reg;
wire [3:0] gap    = 4'h8 - char_len;
wire [7:0] mask   = 8'hFF >> gap;
wire [7:0] shin   = {rxd, sh_reg[7:1]};
wire [7:0] aligned = sh_reg >> gap;
wire [7:0] reload = {1'b0, factor} - 8'h01;
wire       expect_par = (^aligned) ^ ~parity_even;
always @(posedge aclk) begin
    if (!aresetn) begin
        state_reg <= R_IDLE;
        cnt_reg <= 8'h00;
        sh_reg <= 8'h00;
        nb_reg <= 4'h0;
        second_reg <= 1'b0;
        perr_reg <= 1'b0;
        ferr_reg <= 1'b0;
        char_valid <= 1'b0;
        char_data <= 8'h00;
        parity_err <= 1'b0;
        frame_err <= 1'b0;
        sync_found <= 1'b0;
    end else begin
        char_valid <= 1'b0;
        sync_found <= 1'b0;
        if (!enable) begin
            state_reg <= R_IDLE;
        end else if (hunt && sync_mode && !ext_sync) begin
            state_reg <= R_HUNT;
            second_reg <= 1'b0;
        end else if (state_reg == R_IDLE) begin
            nb_reg <= 4'h0;
            second_reg <= 1'b0;
            cnt_reg <= 8'h00;
            if (sync_mode) state_reg <= ext_sync ? R_DATA : R_HUNT;
            else if (tick && !rxd) begin
                state_reg <= R_START;
                cnt_reg <= {2'h0, factor[6:1]};
            end
        end else if (state_reg == R_DONE) begin
            char_data <= aligned;
            parity_err <= perr_reg;
            frame_err <= ferr_reg;
            char_valid <= !second_reg;
            perr_reg <= 1'b0;
            ferr_reg <= 1'b0;
            nb_reg <= 4'h0;
            second_reg <= 1'b0;
            if (second_reg && aligned == (sync2 & mask)) sync_found <= 1'b1;
            state_reg <= !sync_mode ? R_IDLE :
                         (second_reg && aligned != (sync2 & mask)) ? R_HUNT : R_DATA;
        end else if (tick) begin
            if (cnt_reg != 8'h00) begin
                cnt_reg <= cnt_reg - 8'h01;
            end else begin
                cnt_reg <= reload;
                case (state_reg)
                    R_START: state_reg <= rxd ? R_IDLE : R_DATA;
                    R_DATA: begin
                        sh_reg <= shin;
                        nb_reg <= nb_reg + 4'h1;
                        if (nb_reg == char_len - 4'h1)
                            state_reg <= parity_en ? R_PAR : (sync_mode ? R_DONE : R_STOP);
                    end
                    R_PAR: begin
                        perr_reg <= (rxd != expect_par);
                        state_reg <= sync_mode ? R_DONE : R_STOP;
                    end
                    R_STOP: begin
                        ferr_reg <= !rxd;
                        state_reg <= R_DONE;
                    end
                    R_HUNT: begin
                        sh_reg <= shin;
                        if ((shin >> gap) == (sync1 & mask)) begin
                            sync_found <= single_sync;
                            second_reg <= !single_sync;
                            nb_reg <= 4'h0;
                            state_reg <= R_DATA;
                        end
                    end
                    default: state_reg <= R_IDLE;
                endcase
            end
        end
    end
end
endmodule // serial_rx

// *** verilog/serial_usart_control_sequencer.v ***
/*
  Serial communications controller with mode, sync and command sequencing,
  reached as an AXI4-Lite slave. Assumes one clock and a synchronous reset;
  rxd arrives from outside the clock domain.
*/
`timescale 1ns/1ns
`include "serial_usart_defines.vh"
module serial_usart_control_sequencer #(
    parameter ADDR_W = 8
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire [ADDR_W-1:0] awaddr,
    input  wire              awvalid,
    output reg               awready,
    input  wire [31:0]       wdata,
    input  wire [3:0]        wstrb,
    input  wire              wvalid,
    output reg               wready,
    output reg  [1:0]        bresp,
    output reg               bvalid,
    input  wire              bready,
    input  wire [ADDR_W-1:0] araddr,
    input  wire              arvalid,
    output reg               arready,
    output reg  [31:0]       rdata,
    output reg  [1:0]        rresp,
    output reg               rvalid,
    input  wire              rready,
    input  wire              rxd,
    output wire              txd,
    output reg               tx_holding_ready,
    output reg               rx_char_ready,
    output reg               tx_all_empty
);

localparam C_MODE  = 2'h0;
localparam C_SYNC1 = 2'h1;
localparam C_SYNC2 = 2'h2;
localparam C_CMD   = 2'h3;

localparam SEL_NONE = 2'h0;
localparam SEL_DATA = 2'h1;
localparam SEL_CTRL = 2'h2;
localparam SEL_DIV  = 2'h3;

// Maps a byte address onto one of the three registers.
function [1:0] reg_sel;
    input [ADDR_W-1:0] a;
    begin
        if (a == `REG_DATA_OFS) begin
            reg_sel = SEL_DATA;
        end else if (a == `REG_CTRL_OFS) begin
            reg_sel = SEL_CTRL;
        end else if (a == `REG_DIV_OFS) begin
            reg_sel = SEL_DIV;
        end else begin
            reg_sel = SEL_NONE;
        end
    end
endfunction

reg  [ADDR_W-1:0] aw_addr_reg;
reg               aw_full_reg;
reg  [31:0]       w_data_reg;
reg  [3:0]        w_strb_reg;
reg               w_full_reg;
reg  [1:0]        ctrl_state_reg;
reg  [7:0]        mode_reg;
reg  [7:0]        cmd_reg;
reg  [7:0]        sync1_reg;
reg  [7:0]        sync2_reg;
reg  [15:0]       div_reg;
reg  [15:0]       brg_cnt_reg;
reg               tick_reg;
reg  [7:0]        hold_reg;
reg               hold_full_reg;
reg  [7:0]        rx_data_reg;
reg               rx_ready_reg;
reg               pe_reg;
reg               oe_reg;
reg               fe_reg;
reg               syndet_reg;
reg               hunt_reg;
reg               rxd_meta_reg;
reg               rxd_sync_reg;
reg  [6:0]        factor;
reg  [7:0]        stop_ticks;

wire [1:0] wr_sel  = reg_sel(aw_addr_reg);
wire [1:0] rd_sel  = reg_sel(araddr);
wire       do_write = aw_full_reg && w_full_reg && !bvalid;
wire       ar_take  = arvalid && arready;
wire       wr_data  = do_write && wr_sel == SEL_DATA && w_strb_reg[0];
wire       wr_ctrl  = do_write && wr_sel == SEL_CTRL && w_strb_reg[0];
wire       rd_data  = ar_take && rd_sel == SEL_DATA;
wire       rd_stat  = ar_take && rd_sel == SEL_CTRL;
wire [7:0] wbyte    = w_data_reg[7:0];
wire       in_cmd   = (ctrl_state_reg == C_CMD);
wire       sync_mode = (mode_reg[`MODE_BAUD] == `BAUD_SYNC);
wire [3:0] char_len = `LEN_BASE + {2'h0, mode_reg[`MODE_LEN]};
wire       tx_en    = in_cmd && cmd_reg[`CMD_TXEN];
wire       rx_en    = in_cmd && cmd_reg[`CMD_RXE];
wire       ir_cmd   = wr_ctrl && in_cmd && wbyte[`CMD_IR];
wire       er_cmd   = wr_ctrl && in_cmd && wbyte[`CMD_ER];
wire       tx_busy;
wire       tx_load  = tx_en && hold_full_reg && !tx_busy;
wire       rx_valid;
wire [7:0] rx_char;
wire       rx_perr;
wire       rx_ferr;
wire       rx_sync;
wire [7:0] status;

assign status = {1'b0, syndet_reg, fe_reg, oe_reg, pe_reg,
                 tx_all_empty, rx_ready_reg, tx_holding_ready};

// Baud factor and stop length follow the mode in force.
always @* begin
    case (mode_reg[`MODE_BAUD])
        `BAUD_X16: factor = `FACT_X16;
        `BAUD_X64: factor = `FACT_X64;
        default:   factor = `FACT_X1;
    endcase
    case (mode_reg[`MODE_STOP])
        `STOP_15: stop_ticks = {1'b0, factor} + {2'h0, factor[6:1]};
        `STOP_2:  stop_ticks = {factor, 1'b0};
        default:  stop_ticks = {1'b0, factor};
    endcase
end

// Two-stage synchroniser for the serial input.
always @(posedge aclk) begin
    if (!aresetn) begin
        rxd_meta_reg <= 1'b1;
        rxd_sync_reg <= 1'b1;
    end else begin
        rxd_meta_reg <= rxd;
        rxd_sync_reg <= rxd_meta_reg;
    end
end

// Sampling-clock divider, one tick every div_reg plus one cycles.
always @(posedge aclk) begin
    if (!aresetn) begin
        brg_cnt_reg <= 16'h0000;
        tick_reg    <= 1'b0;
    end else if (brg_cnt_reg == 16'h0000) begin
        brg_cnt_reg <= div_reg;
        tick_reg    <= 1'b1;
    end else begin
        brg_cnt_reg <= brg_cnt_reg - 16'h0001;
        tick_reg    <= 1'b0;
    end
end

// Write channel: address and data taken in either order, answered after both.
always @(posedge aclk) begin
    if (!aresetn) begin
        awready     <= 1'b1;
        wready      <= 1'b1;
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        aw_addr_reg <= {ADDR_W{1'b0}};
        w_data_reg  <= 32'h00000000;
        w_strb_reg  <= 4'h0;
        bvalid      <= 1'b0;
        bresp       <= `RESP_OKAY;
    end else begin
        if (awvalid && awready) begin
            aw_addr_reg <= awaddr;
            aw_full_reg <= 1'b1;
            awready     <= 1'b0;
        end
        if (wvalid && wready) begin
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
            w_full_reg <= 1'b1;
            wready     <= 1'b0;
        end
        if (do_write) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            bvalid      <= 1'b1;
            bresp       <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end else if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
        end
    end
end

// Read channel: answered one cycle after the address is taken.
always @(posedge aclk) begin
    if (!aresetn) begin
        arready <= 1'b1;
        rvalid  <= 1'b0;
        rdata   <= 32'h00000000;
        rresp   <= `RESP_OKAY;
    end else if (ar_take) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= `RESP_OKAY;
        if (rd_sel == SEL_DATA) begin
            rdata <= {24'h000000, rx_data_reg};
        end else if (rd_sel == SEL_CTRL) begin
            rdata <= {24'h000000, status};
        end else if (rd_sel == SEL_DIV) begin
            rdata <= {16'h0000, div_reg};
        end else begin
            rdata <= 32'h00000000;
            rresp <= `RESP_SLVERR;
        end
    end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
    end
end

// Control-word sequencer: mode, optional sync characters, then commands.
always @(posedge aclk) begin
    if (!aresetn) begin
        ctrl_state_reg <= C_MODE;
        mode_reg       <= 8'h00;
        cmd_reg        <= 8'h00;
        sync1_reg      <= 8'h00;
        sync2_reg      <= 8'h00;
        div_reg        <= `DIV_RESET;
        hunt_reg       <= 1'b0;
    end else begin
        hunt_reg <= 1'b0;
        if (do_write && wr_sel == SEL_DIV) begin
            if (w_strb_reg[0]) div_reg[7:0] <= w_data_reg[7:0];
            if (w_strb_reg[1]) div_reg[15:8] <= w_data_reg[15:8];
        end
        if (wr_ctrl) begin
            case (ctrl_state_reg)
                C_MODE: begin
                    mode_reg <= wbyte;
                    cmd_reg  <= 8'h00;
                    if (wbyte[`MODE_BAUD] == `BAUD_SYNC) begin
                        ctrl_state_reg <= C_SYNC1;
                    end else begin
                        ctrl_state_reg <= C_CMD;
                    end
                end
                C_SYNC1: begin
                    sync1_reg <= wbyte;
                    ctrl_state_reg <= mode_reg[`MODE_SCS] ? C_CMD : C_SYNC2;
                end
                C_SYNC2: begin
                    sync2_reg <= wbyte;
                    ctrl_state_reg <= C_CMD;
                end
                default: begin
                    if (wbyte[`CMD_IR]) begin
                        ctrl_state_reg <= C_MODE;
                        cmd_reg        <= 8'h00;
                    end else begin
                        cmd_reg  <= wbyte;
                        hunt_reg <= wbyte[`CMD_EH];
                    end
                end
            endcase
        end
    end
end

// Transmit holding buffer and ready flags; a new write wins over a load.
always @(posedge aclk) begin
    if (!aresetn) begin
        hold_reg         <= 8'h00;
        hold_full_reg    <= 1'b0;
        tx_holding_ready <= 1'b0;
        tx_all_empty     <= 1'b1;
    end else begin
        if (wr_data) begin
            hold_reg      <= wbyte;
            hold_full_reg <= 1'b1;
        end else if (tx_load || ir_cmd) begin
            hold_full_reg <= 1'b0;
        end
        tx_holding_ready <= tx_en && !hold_full_reg && !wr_data;
        tx_all_empty     <= !hold_full_reg && !tx_busy && !wr_data && !tx_load;
    end
end

// Receive buffer and status flags; a hardware set wins over a clear.
always @(posedge aclk) begin
    if (!aresetn) begin
        rx_data_reg   <= 8'h00;
        rx_ready_reg  <= 1'b0;
        rx_char_ready <= 1'b0;
        pe_reg        <= 1'b0;
        oe_reg        <= 1'b0;
        fe_reg        <= 1'b0;
        syndet_reg    <= 1'b0;
    end else begin
        if (rx_valid) begin
            rx_data_reg  <= rx_char;
            rx_ready_reg <= 1'b1;
        end else if (rd_data || ir_cmd) begin
            rx_ready_reg <= 1'b0;
        end
        rx_char_ready <= (rx_valid || rx_ready_reg) && !((rd_data || ir_cmd) && !rx_valid);
        if (rx_valid && rx_ready_reg) oe_reg <= 1'b1;
        else if (er_cmd || ir_cmd) oe_reg <= 1'b0;
        if (rx_valid && rx_perr) pe_reg <= 1'b1;
        else if (er_cmd || ir_cmd) pe_reg <= 1'b0;
        if (rx_valid && rx_ferr) fe_reg <= 1'b1;
        else if (er_cmd || ir_cmd) fe_reg <= 1'b0;
        if (rx_sync) syndet_reg <= 1'b1;
        else if (rd_stat || ir_cmd) syndet_reg <= 1'b0;
    end
end

serial_tx u_tx (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .tick        (tick_reg),
    .load        (tx_load),
    .data        (hold_reg),
    .factor      (factor),
    .stop_ticks  (stop_ticks),
    .char_len    (char_len),
    .parity_en   (mode_reg[`MODE_PEN]),
    .parity_even (mode_reg[`MODE_EP]),
    .sync_mode   (sync_mode),
    .brk         (in_cmd && cmd_reg[`CMD_SBRK]),
    .txd         (txd),
    .busy        (tx_busy)
);

serial_rx u_rx (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .rxd         (rxd_sync_reg),
    .tick        (tick_reg),
    .enable      (rx_en),
    .hunt        (hunt_reg),
    .sync_mode   (sync_mode),
    .ext_sync    (mode_reg[`MODE_ESD]),
    .single_sync (mode_reg[`MODE_SCS]),
    .factor      (factor),
    .char_len    (char_len),
    .parity_en   (mode_reg[`MODE_PEN]),
    .parity_even (mode_reg[`MODE_EP]),
    .sync1       (sync1_reg),
    .sync2       (sync2_reg),
    .char_valid  (rx_valid),
    .char_data   (rx_char),
    .parity_err  (rx_perr),
    .frame_err   (rx_ferr),
    .sync_found  (rx_sync)
);

endmodule // serial_usart_control_sequencer

// *** bench/serial_usart_asserts.sv ***
/* Checker of the serial controller top: bus answers, response codes, flags.
   Assumes one clock and a synchronous active-low reset; bound below. */
`timescale 1ns/1ns
module serial_usart_asserts #(parameter ADDR_W = 8) (
    input logic aclk,
    input logic aresetn,
    input logic [ADDR_W-1:0] awaddr,
    input logic awvalid,
    input logic awready,
    input logic wvalid,
    input logic wready,
    input logic [1:0] bresp,
    input logic bvalid,
    input logic bready,
    input logic [ADDR_W-1:0] araddr,
    input logic arvalid,
    input logic arready,
    input logic [31:0] rdata,
    input logic [1:0] rresp,
    input logic rvalid,
    input logic rready,
    input logic txd,
    input logic tx_holding_ready,
    input logic rx_char_ready,
    input logic tx_all_empty
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [ADDR_W-1:0] aw_q;
    always @(posedge aclk) if (awvalid && awready) aw_q <= awaddr;
    wire aw_map = aw_q == 0 || aw_q == 4 || aw_q == 8;
    wire ar_map = araddr == 0 || araddr == 4 || araddr == 8;
    chk_reset_idle: assert property ($rose(aresetn) |-> awready && arready
        && !bvalid && !rvalid && txd && tx_all_empty && !tx_holding_ready) else $error("bad reset");
    chk_write_answer: assert property (awvalid && awready && wvalid && wready
        |=> !awready && !wready ##1 bvalid) else $error("write answer late");
    chk_b_code: assert property (bvalid |-> bresp == (aw_map ? 2'h0 : 2'h2))
        else $error("write response wrong");
    chk_w_release: assert property (bvalid && bready |=> awready && wready && !bvalid)
        else $error("write not closed");
    chk_read_answer: assert property (arvalid && arready |=> !arready && rvalid)
        else $error("read answer late");
    chk_r_release: assert property (rvalid && rready |=> arready && !rvalid)
        else $error("read not closed");
    chk_r_unmapped: assert property (arvalid && arready && !ar_map
        |=> rvalid && rresp == 2'h2 && rdata == 32'h0) else $error("unmapped read wrong");
    chk_rx_clear: assert property (arvalid && arready && araddr == 0 |-> ##2 !rx_char_ready)
        else $error("receive flag not cleared");
    cover property (bvalid && bresp == 2'h2);
    cover property (rx_char_ready && rvalid);
    cover property ($fell(tx_all_empty));
endmodule // serial_usart_asserts
bind serial_usart_control_sequencer serial_usart_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

// *** bench/serial_line_model.sv ***
/* Remote serial equipment: frames of 8 data bits, no parity, one stop bit.
   Assumes BITC clocks a bit; the line idles high as a marking RS232 line. */
`timescale 1ns/1ns
module serial_line_model #(parameter BITC = 32) (
    input  logic clk,
    input  logic txd,
    output logic rxd
);
    logic [7:0] got[$];
    logic [7:0] sh;
    initial rxd = 1'b1;
    always begin
        @(negedge txd);
        repeat (BITC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BITC) @(posedge clk);
            sh[i] = txd;
        end
        got.push_back(sh);
        repeat (BITC) @(posedge clk);
    end
    task send(input logic [7:0] b);
        for (int i = -1; i < 9; i++) begin
            rxd <= (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : b[i];
            repeat (BITC) @(posedge clk);
        end
    endtask
endmodule // serial_line_model

// *** bench/serial_usart_control_sequencer_tb.sv ***
/* Testbench of the serial controller: mode, sync and command sequence, data both ways.
   Assumes the divider resets to 1, so a bit at factor 16 lasts 32 clocks. */
`timescale 1ns/1ns
module serial_usart_control_sequencer_tb;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic rxd, txd, tx_holding_ready, rx_char_ready, tx_all_empty;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, b, r;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp;
    logic [7:0] exp_q[$];
    int num_errors = 0, n_checks = 0, seed = 32'hab4a, t;
    always #5 aclk = ~aclk;
    serial_usart_control_sequencer uut (.*);
    serial_line_model #(.BITC(32)) lm (.clk(aclk), .txd(txd), .rxd(rxd));
    task stop_test;
        if (num_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task check(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task hang;
        num_errors++;
        $display("[FAIL] %0t no answer", $time);
        stop_test;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (k = 0; k < 99; k++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (k == 99) hang;
        v = {30'h0, bresp};
        bready <= 1'b0;
        repeat (16) @(posedge aclk);
    endtask
    task rd(input logic [7:0] a);
        int k;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (k = 0; k < 99; k++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (k == 99) hang;
        v = rdata;
        rready <= 1'b0;
    endtask
    task poll(input logic [31:0] m);
        int k;
        for (k = 0; k < 300; k++) begin
            rd(8'h04);
            if ((v & m) != 0) break;
        end
        if (k == 300) hang;
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        check(tx_holding_ready, 1'b0);
        check(tx_all_empty, 1'b1);
        rd(8'h08); check(v, 32'h1);
        rd(8'h0C); check(rresp, 2'h2);
        wr(8'h0C, 32'h0); check(v, 32'h2);
        wr(8'h04, 32'h8C);
        wr(8'h04, 32'h40);
        wr(8'h04, 32'h01);
        rd(8'h04); check(v[0], 1'b1);
        check(tx_holding_ready, 1'b1);
        poll(32'h1);
        wr(8'h04, 32'h40);
        rd(8'h04); check(v[0], 1'b0);
        wr(8'h04, 32'h4E);
        rd(8'h04); check(v[0], 1'b0);
        wr(8'h04, 32'h05);
        repeat (3) begin
            b = $random(seed);
            r = $random(seed);
            poll(32'h1);
            wr(8'h00, {24'h0, b});
            exp_q.push_back(b);
            check(tx_all_empty, 1'b0);
            lm.send(r);
            poll(32'h2);
            check(rx_char_ready, 1'b1);
            rd(8'h00); check(v, {24'h0, r});
            check(rx_char_ready, 1'b0);
            for (t = 0; t < 400 && lm.got.size() == 0; t++) @(posedge aclk);
            if (t == 400) hang;
            check(lm.got.pop_front(), exp_q.pop_front());
        end
        stop_test;
    end
endmodule // serial_usart_control_sequencer_tb
